//--- logic/call_dispatch_defs.vh
// Constants for the supervisory call dispatcher and processor flag register
`ifndef CALL_DISPATCH_DEFS_VH
`define CALL_DISPATCH_DEFS_VH

`define CALL_OPCODE          8'h00
`define FLAGS_ADDR           8'hF7
`define FLAGS_RESET          8'h02
`define FLAGS_WRITE_MASK     8'hD7
`define FLAG_PAGE_HI         7
`define FLAG_PAGE_LO         6
`define FLAG_BANK            4
`define FLAG_CARRY           2
`define FLAG_ZERO            1
`define FLAG_GIE             0
`define FLAGOP_NONE          2'h0
`define FLAGOP_AND           2'h1
`define FLAGOP_OR            2'h2
`define FLAGOP_XOR           2'h3

`define FN_SOFT_BOOT         8'h00
`define FN_BLOCK_FETCH       8'h01
`define FN_BLOCK_PROGRAM     8'h02
`define FN_BLOCK_CLEAR       8'h03
`define FN_TABLE_FETCH       8'h06
`define FN_SUM               8'h07
`define FN_FIRST_TRIM        8'h08
`define FN_SECOND_TRIM       8'h09
`define FN_PROGRAM_VERIFY    8'h0A
`define FN_HARD_REBOOT       8'h0F

`define PB_FIRST_CALL_KEY              8'hF8
`define PB_SECOND_CALL_KEY              8'hF9
`define PB_BLOCK             8'hFA
`define PB_POINTER           8'hFB
`define PB_CLOCK             8'hFC
`define PB_DELAY             8'hFE
`define FIRST_CALL_KEY_VALUE           8'h3A
`define SECOND_CALL_KEY_SP_OFFSET       8'h03

`define RC_SUCCESS           8'h00
`define RC_PROTECTED         8'h01
`define RC_SOFT_RESET        8'h02
`define RC_FATAL             8'h03

`define SRAM_PAGE0           3'h0
`define PROT_READ            0
`define PROT_WRITE           1

`endif

//--- logic/processor_flags_reg.v
// Processor flag register with flag-logic updates, call save and restore
`default_nettype none
`include "call_dispatch_defs.vh"

module processor_flags_reg (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [1:0] flagOp,
    input  wire [7:0] flagImm,
    input  wire       regWrEn,
    input  wire [7:0] regWrAddr,
    input  wire [7:0] regWrData,
    input  wire       aluUpdate,
    input  wire       aluCarry,
    input  wire       aluZero,
    input  wire       irqTaken,
    input  wire       callSave,
    input  wire       callRestore,
    output wire [7:0] flags
);

    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [7:0] saved_q;

    assign flags = flags_q;

    always @*
    begin
        flags_d = flags_q;
        case (flagOp)
            `FLAGOP_AND: flags_d = flags_q & flagImm;
            `FLAGOP_OR:  flags_d = flags_q | flagImm;
            `FLAGOP_XOR: flags_d = flags_q ^ flagImm;
            default:     flags_d = flags_q;
        endcase
        if (regWrEn && regWrAddr == `FLAGS_ADDR)
        begin
            flags_d = regWrData;
        end
        if (aluUpdate)
        begin
            flags_d[`FLAG_CARRY] = aluCarry;
            flags_d[`FLAG_ZERO]  = aluZero;
        end
        if (irqTaken)
        begin
            flags_d[`FLAG_GIE] = 1'b0;
        end
        if (callSave)
        begin
            flags_d[`FLAG_PAGE_HI] = 1'b0;
            flags_d[`FLAG_PAGE_LO] = 1'b0;
        end
        if (callRestore)
        begin
            flags_d = saved_q;
        end
        // Reserved bits hold zero
        flags_d = flags_d & `FLAGS_WRITE_MASK;
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= `FLAGS_RESET;
            saved_q <= `FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
            if (callSave)
            begin
                saved_q <= flags_q;
            end
        end
    end

endmodule
`default_nettype wire

//--- logic/supervisory_call_dispatch.v
// Supervisory call dispatcher: function decode, key check, return code
`default_nettype none
`include "call_dispatch_defs.vh"

module supervisory_call_dispatch (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        instrValid,
    input  wire [7:0]  instrOpcode,
    input  wire [15:0] instrPc,
    input  wire [7:0]  accumulator,
    input  wire [7:0]  stackPointer,
    input  wire [1:0]  flagOp,
    input  wire [7:0]  flagImm,
    input  wire        regWrEn,
    input  wire [7:0]  regWrAddr,
    input  wire [7:0]  regWrData,
    input  wire        aluUpdate,
    input  wire        aluCarry,
    input  wire        aluZero,
    input  wire        irqRequest,
    input  wire        irqPushDone,
    input  wire [7:0]  indirectReadPage,
    input  wire [7:0]  indirectWritePage,
    input  wire        fnDone,
    input  wire        fnSoftReset,
    input  wire        fnFatal,
    input  wire [7:0]  fnResultData,
    input  wire [1:0]  blockProtect,
    output wire [7:0]  flags,
    output wire [1:0]  ramPagingSelect,
    output wire        registerBankSelect,
    output wire        globalInterruptEnable,
    output wire        irqAccept,
    output reg         callBusy,
    output reg         cpuHalt,
    output reg         hardReboot,
    output reg         softReboot,
    output reg         fnStart,
    output reg  [7:0]  fnCode,
    output reg  [7:0]  bufferPage,
    output reg         pbWrEn,
    output reg  [7:0]  pbWrAddr,
    output reg  [7:0]  pbWrData,
    output reg         resumeValid,
    output reg  [15:0] resumePc
);

    // ****************************************
    // Function decode
    // ****************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN  = 2'd1;
    localparam ST_HALT = 2'd2;

    reg [1:0] state_q;
    reg [7:0] pbKey1_q;
    reg [7:0] pbKey2_q;

    function isDefined;
        input [7:0] code;
        begin
            isDefined = (code == `FN_SOFT_BOOT) || (code == `FN_BLOCK_FETCH)
                || (code == `FN_BLOCK_PROGRAM) || (code == `FN_BLOCK_CLEAR)
                || (code == `FN_TABLE_FETCH) || (code == `FN_SUM)
                || (code == `FN_FIRST_TRIM) || (code == `FN_SECOND_TRIM)
                || (code == `FN_PROGRAM_VERIFY) || (code == `FN_HARD_REBOOT);
        end
    endfunction

    function isBlockOp;
        input [7:0] code;
        begin
            isBlockOp = (code == `FN_BLOCK_FETCH) || (code == `FN_BLOCK_PROGRAM)
                || (code == `FN_BLOCK_CLEAR) || (code == `FN_PROGRAM_VERIFY);
        end
    endfunction

    function hasReturnCode;
        input [7:0] code;
        begin
            hasReturnCode = (code != `FN_SUM) && (code != `FN_TABLE_FETCH);
        end
    endfunction

    // ****************************************
    // Parameter block keys
    // ****************************************
    // Keys are snooped from register writes in any page so the check needs no SRAM read port
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pbKey1_q <= `RC_SUCCESS;
            pbKey2_q <= `RC_SUCCESS;
        end
        else
        begin
            if (regWrEn && regWrAddr == `PB_FIRST_CALL_KEY)
            begin
                pbKey1_q <= regWrData;
            end
            // Return code lands in the first key, so a repeat call needs fresh keys
            else if (pbWrEn && pbWrAddr == `PB_FIRST_CALL_KEY)
            begin
                pbKey1_q <= pbWrData;
            end
            if (regWrEn && regWrAddr == `PB_SECOND_CALL_KEY)
            begin
                pbKey2_q <= regWrData;
            end
        end
    end

    wire callIssue = instrValid && (instrOpcode == `CALL_OPCODE) && (state_q == ST_IDLE);
    wire key1Ok    = (pbKey1_q == `FIRST_CALL_KEY_VALUE);
    // second key from stack pointer
    // Stack pointer is live, so the match is only valid at the call edge
    wire key2Ok    = (pbKey2_q == stackPointer + `SECOND_CALL_KEY_SP_OFFSET);
    wire skipKeys  = (accumulator == `FN_SOFT_BOOT);
    wire blockProt = (fnCode == `FN_BLOCK_FETCH) ? blockProtect[`PROT_READ] : blockProtect[`PROT_WRITE];

    // ****************************************
    // Flags
    // ****************************************
    // Save on the call edge itself, before any function step touches the flags
    wire callSave    = callIssue;
    // Protected block op ends the call at once, without waiting for the engine
    wire callRestore = (state_q == ST_RUN)
        && (fnDone || fnFatal || fnSoftReset || (isBlockOp(fnCode) && blockProt));

    processor_flags_reg flagsReg (
        .core_clk    (core_clk),
        .rst         (rst),
        .flagOp      (flagOp),
        .flagImm     (flagImm),
        .regWrEn     (regWrEn),
        .regWrAddr   (regWrAddr),
        .regWrData   (regWrData),
        .aluUpdate   (aluUpdate),
        .aluCarry    (aluCarry),
        .aluZero     (aluZero),
        .irqTaken    (irqPushDone),
        .callSave    (callSave),
        .callRestore (callRestore),
        .flags       (flags)
    );

    assign ramPagingSelect       = flags[`FLAG_PAGE_HI:`FLAG_PAGE_LO];
    assign registerBankSelect    = flags[`FLAG_BANK];
    assign globalInterruptEnable = flags[`FLAG_GIE];
    // request gated by enable
    // No interrupt is accepted while a call runs, as both need the idle state; a call and an interrupt can still both fire in the same idle cycle
    assign irqAccept = instrValid && irqRequest && flags[`FLAG_GIE] && (state_q == ST_IDLE);

    // ****************************************
    // Dispatcher
    // ****************************************
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q     <= ST_IDLE;
            callBusy    <= 1'b0;
            cpuHalt     <= 1'b0;
            hardReboot  <= 1'b0;
            softReboot  <= 1'b0;
            fnStart     <= 1'b0;
            fnCode      <= `FN_SOFT_BOOT;
            bufferPage  <= 8'h00;
            pbWrEn      <= 1'b0;
            pbWrAddr    <= `PB_FIRST_CALL_KEY;
            pbWrData    <= `RC_SUCCESS;
            resumeValid <= 1'b0;
            resumePc    <= 16'h0000;
        end
        else
        begin
            fnStart     <= 1'b0;
            pbWrEn      <= 1'b0;
            resumeValid <= 1'b0;
            hardReboot  <= 1'b0;
            softReboot  <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (callIssue)
                    begin
                        fnCode   <= accumulator;
                        resumePc <= instrPc + 16'h0001;
                        bufferPage <= (accumulator == `FN_BLOCK_FETCH) ? indirectWritePage : indirectReadPage;
                        if (!isDefined(accumulator))
                        begin
                            state_q <= ST_HALT;
                            cpuHalt <= 1'b1;
                        end
                        else if (!skipKeys && !(key1Ok && key2Ok))
                        begin
                            state_q <= ST_HALT;
                            cpuHalt <= 1'b1;
                        end
                        // Reboot leaves no return code, a reset follows
                        else if (accumulator == `FN_HARD_REBOOT)
                        begin
                            hardReboot <= 1'b1;
                            state_q    <= ST_HALT;
                        end
                        else
                        begin
                            state_q  <= ST_RUN;
                            callBusy <= 1'b1;
                            fnStart  <= 1'b1;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (callRestore)
                    begin
                        state_q  <= ST_IDLE;
                        callBusy <= 1'b0;
                        pbWrEn   <= 1'b1;
                        pbWrAddr <= `PB_FIRST_CALL_KEY;
                        // return code values
                        // Fatal still restores flags, but the core stays halted
                        if (fnFatal)
                        begin
                            pbWrData <= `RC_FATAL;
                            cpuHalt  <= 1'b1;
                            state_q  <= ST_HALT;
                        end
                        else if (isBlockOp(fnCode) && blockProt)
                        begin
                            pbWrData <= `RC_PROTECTED;
                        end
                        else if (fnSoftReset)
                        begin
                            pbWrData   <= `RC_SOFT_RESET;
                            softReboot <= 1'b1;
                        end
                        else if (!hasReturnCode(fnCode))
                        begin
                            pbWrData <= fnResultData;
                        end
                        else
                        begin
                            pbWrData <= `RC_SUCCESS;
                        end
                        if (!fnFatal && !fnSoftReset)
                        begin
                            resumeValid <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    // Halt is left only by reset
                    state_q <= ST_HALT;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- verif/supervisory_call_dispatch_assertions.sv
// Port checker for the supervisory call dispatcher
`default_nettype none
module supervisory_call_dispatch_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        instrValid,
    input wire logic [7:0]  instrOpcode,
    input wire logic [15:0] instrPc,
    input wire logic [7:0]  accumulator,
    input wire logic [7:0]  stackPointer,
    input wire logic        regWrEn,
    input wire logic [7:0]  regWrAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        irqPushDone,
    input wire logic        fnDone,
    input wire logic [7:0]  fnResultData,
    input wire logic [1:0]  blockProtect,
    input wire logic [7:0]  flags,
    input wire logic [1:0]  ramPagingSelect,
    input wire logic        globalInterruptEnable,
    input wire logic        irqAccept,
    input wire logic        callBusy,
    input wire logic        cpuHalt,
    input wire logic        hardReboot,
    input wire logic        fnStart,
    input wire logic [7:0]  fnCode,
    input wire logic        pbWrEn,
    input wire logic [7:0]  pbWrAddr,
    input wire logic [7:0]  pbWrData,
    input wire logic        resumeValid,
    input wire logic [15:0] resumePc
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0]  k1Q;
    logic [7:0]  k2Q;
    logic [7:0]  flagsQ;
    logic [15:0] pcQ;
    wire take = instrValid && instrOpcode == 8'h00 && !callBusy && !cpuHalt;
    wire known = accumulator inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0F};
    wire keysOk = k1Q == 8'h3A && k2Q == stackPointer + 8'h03;
    wire sumTable = fnCode == 8'h06 || fnCode == 8'h07;
    // Mirrors of the keys, snooped like the dispatcher does
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            k1Q <= 8'h00;
            k2Q <= 8'h00;
        end
        else
        begin
            if (regWrEn && regWrAddr == 8'hF8)
                k1Q <= regWrData;
            else if (pbWrEn && pbWrAddr == 8'hF8)
                k1Q <= pbWrData;
            if (regWrEn && regWrAddr == 8'hF9)
                k2Q <= regWrData;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (take)
        begin
            flagsQ <= flags;
            pcQ <= instrPc;
        end
    end
    sequence callTaken;
        take;
    endsequence
    sequence codeWritten;
        pbWrEn && pbWrAddr == 8'hF8 && resumeValid;
    endsequence
    call_entry_a: assert property (callTaken ##0 known |=> fnStart || cpuHalt || hardReboot)
        else $error("call not answered");
    undefined_halt_a: assert property (callTaken ##0 !known |=> cpuHalt && !fnStart)
        else $error("undefined code ran");
    key_halt_a: assert property (callTaken ##0 known && accumulator != 8'h00 && !keysOk |=> cpuHalt && !fnStart)
        else $error("bad key not halted");
    soft_boot_a: assert property (callTaken ##0 accumulator == 8'h00 |=> fnStart && fnCode == 8'h00)
        else $error("soft boot refused");
    paging_clear_a: assert property (fnStart |-> ramPagingSelect == 2'b00 && callBusy)
        else $error("paging bits kept");
    flags_restore_a: assert property ($fell(callBusy) |-> flags == flagsQ)
        else $error("flags not restored");
    return_ok_a: assert property (fnDone && callBusy && !sumTable |=> codeWritten ##0 pbWrData == 8'h00)
        else $error("bad success code");
    result_data_a: assert property (fnDone && callBusy && sumTable |=> codeWritten ##0 pbWrData == $past(fnResultData))
        else $error("bad result data");
    protect_a: assert property (callBusy && fnCode == 8'h01 && blockProtect[0] |-> ##[1:2] pbWrEn && pbWrData == 8'h01)
        else $error("protected fetch ran");
    resume_a: assert property (resumeValid |-> resumePc == pcQ + 16'h0001)
        else $error("bad resume address");
    gie_clear_a: assert property (irqPushDone |=> !globalInterruptEnable)
        else $error("enable kept after push");
    irq_gate_a: assert property (irqAccept |-> globalInterruptEnable && instrValid)
        else $error("request taken while disabled");
endmodule
bind supervisory_call_dispatch supervisory_call_dispatch_checker u_supervisory_call_dispatch_checker (.*);
`default_nettype wire

//--- verif/function_engine_model.sv
// Behavioural function engine answering dispatcher starts
`default_nettype none
module function_engine_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       fnStart,
    input  wire logic [7:0] fnCode,
    input  wire logic       pbWrEn,
    input  wire logic [1:0] endKind,
    input  wire logic [7:0] latency,
    output var logic        fnDone,
    output var logic        fnSoftReset,
    output var logic        fnFatal,
    output var logic [7:0]  fnResultData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt;
    logic       busyQ;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            busyQ <= 1'b0;
            cnt <= 8'h00;
            fnDone <= 1'b0;
            fnSoftReset <= 1'b0;
            fnFatal <= 1'b0;
            fnResultData <= 8'h00;
        end
        else
        begin
            fnDone <= 1'b0;
            fnSoftReset <= 1'b0;
            fnFatal <= 1'b0;
            // Result bus only valid with the done pulse
            fnResultData <= ~fnResultData;
            if (fnStart)
            begin
                busyQ <= 1'b1;
                cnt <= latency;
            end
            else if (pbWrEn)
                busyQ <= 1'b0;
            else if (busyQ && cnt != 8'h00)
                cnt <= cnt - 8'h01;
            else if (busyQ)
            begin
                busyQ <= 1'b0;
                fnDone <= endKind == 2'h0;
                fnSoftReset <= endKind == 2'h1;
                fnFatal <= endKind == 2'h2;
                fnResultData <= 8'hA5 ^ fnCode;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/supervisory_call_dispatch_test.sv
// Self-checking bench for the supervisory call dispatcher
`default_nettype none
module supervisory_call_dispatch_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, regWrEn = 1'b0, aluUpdate = 1'b0;
    logic aluCarry = 1'b0, aluZero = 1'b0, irqRequest = 1'b0, irqPushDone = 1'b0;
    logic [7:0] instrOpcode = 8'h00, accumulator = 8'h00, stackPointer = 8'h40, flagImm = 8'h00;
    logic [7:0] regWrAddr = 8'h00, regWrData = 8'h00, indirectReadPage = 8'h03, indirectWritePage = 8'h05;
    logic [7:0] latency = 8'h00, fnResultData, fnCode, bufferPage, pbWrAddr, pbWrData, flags;
    logic [15:0] instrPc = 16'h0000, resumePc, rc, ev, expRc;
    logic [1:0] flagOp = 2'h0, blockProtect = 2'h0, endKind = 2'h0, ramPagingSelect;
    logic registerBankSelect, globalInterruptEnable, irqAccept, callBusy, cpuHalt, hardReboot, softReboot;
    logic fnStart, pbWrEn, resumeValid, fnDone, fnSoftReset, fnFatal, sawSoft;
    logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
    logic [7:0] hAcc [4] = '{8'h01, 8'h08, 8'h05, 8'h0F};
    logic [7:0] hK1 [4] = '{8'h00, 8'h3A, 8'h3A, 8'h3A};
    logic [7:0] hK2 [4] = '{8'h43, 8'h42, 8'h43, 8'h43};
    int n_mismatch = 0;
    int n_compared = 0;
    supervisory_call_dispatch u_supervisory_call_dispatch (.*);
    function_engine_model u_function_engine_model (.*);
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic doReset();
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrEn <= 1'b1;
        regWrAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic flagWr(input logic [1:0] op, input logic [7:0] imm);
        @(posedge core_clk);
        flagOp <= op;
        flagImm <= imm;
        @(posedge core_clk);
        flagOp <= 2'h0;
        #1;
    endtask
    // Keys, paging flags set, then the call; waits for its first outcome
    task automatic runCall(input logic [7:0] acc, input logic [7:0] k1, input logic [7:0] k2);
        regWr(8'hF8, k1);
        regWr(8'hF9, k2);
        regWr(8'hF7, 8'hD5);
        @(posedge core_clk);
        instrValid <= 1'b1;
        accumulator <= acc;
        instrPc <= instrPc + 16'h0010;
        @(posedge core_clk);
        instrValid <= 1'b0;
        ev = 16'h0000;
        sawSoft = 1'b0;
        for (int i = 0; i < 100 && ev == 16'h0000; i++)
        begin
            #1;
            sawSoft = sawSoft | (softReboot === 1'b1);
            if (pbWrEn === 1'b1)
            begin
                ev = 16'h0001;
                rc = 16'(pbWrData);
                chk("resume address", instrPc + 16'h0001, resumePc);
                chk("restored flags", 16'h00D5, 16'(flags));
                if (acc == 8'h01) chk("fetch page", 16'h0005, 16'(bufferPage));
                if (acc == 8'h02) chk("program page", 16'h0003, 16'(bufferPage));
            end
            else if (hardReboot === 1'b1)
                ev = 16'h0003;
            else if (cpuHalt === 1'b1)
                ev = 16'h0002;
            @(posedge core_clk);
        end
    endtask
    initial
    begin
        doReset();
        #1;
        chk("reset flags", 16'h0002, 16'(flags));
        flagWr(2'h2, 8'hD7);
        chk("or flags", 16'h00D7, 16'(flags));
        flagWr(2'h1, 8'h51);
        chk("and flags", 16'h0051, 16'(flags));
        chk("bank select", 16'h0001, 16'(registerBankSelect));
        flagWr(2'h3, 8'hC1);
        chk("xor flags", 16'h0090, 16'(flags));
        chk("paging select", 16'h0002, 16'(ramPagingSelect));
        @(posedge core_clk);
        aluUpdate <= 1'b1;
        aluCarry <= 1'b1;
        aluZero <= 1'b1;
        @(posedge core_clk);
        aluUpdate <= 1'b0;
        #1;
        chk("alu flags", 16'h0096, 16'(flags));
        flagWr(2'h2, 8'h01);
        @(posedge core_clk);
        instrValid <= 1'b1;
        instrOpcode <= 8'h40;
        irqRequest <= 1'b1;
        #1;
        chk("irq accepted", 16'h0001, 16'(irqAccept));
        @(posedge core_clk);
        instrValid <= 1'b0;
        irqPushDone <= 1'b1;
        @(posedge core_clk);
        irqPushDone <= 1'b0;
        instrValid <= 1'b1;
        #1;
        chk("enable cleared", 16'h0000, 16'(globalInterruptEnable));
        chk("irq ignored", 16'h0000, 16'(irqAccept));
        @(posedge core_clk);
        instrValid <= 1'b0;
        instrOpcode <= 8'h00;
        irqRequest <= 1'b0;
        foreach (codes[i])
        begin
            latency <= i[0] ? 8'h28 : 8'h00;
            runCall(codes[i], 8'h3A, 8'h43);
            chk("completion", 16'h0001, ev);
            // Sum and table hand back the engine's data instead of a code
            expRc = (codes[i] == 8'h06 || codes[i] == 8'h07) ? 16'(8'hA5 ^ codes[i]) : 16'h0000;
            chk("return code", expRc, rc);
        end
        endKind <= 2'h1;
        runCall(8'h02, 8'h3A, 8'h43);
        chk("soft reset code", 16'h0002, rc);
        chk("soft reboot", 16'h0001, 16'(sawSoft));
        endKind <= 2'h0;
        blockProtect <= 2'h1;
        runCall(8'h01, 8'h3A, 8'h43);
        chk("read protected", 16'h0001, rc);
        runCall(8'h02, 8'h3A, 8'h43);
        chk("program allowed", 16'h0000, rc);
        blockProtect <= 2'h2;
        runCall(8'h03, 8'h3A, 8'h43);
        chk("write protected", 16'h0001, rc);
        blockProtect <= 2'h0;
        runCall(8'h00, 8'h00, 8'h00);
        chk("soft boot runs", 16'h0001, ev);
        endKind <= 2'h2;
        runCall(8'h02, 8'h3A, 8'h43);
        chk("fatal code", 16'h0003, rc);
        repeat (2) @(posedge core_clk);
        #1;
        chk("fatal halt", 16'h0001, 16'(cpuHalt));
        @(posedge core_clk);
        endKind <= 2'h0;
        doReset();
        foreach (hAcc[i])
        begin
            runCall(hAcc[i], hK1[i], hK2[i]);
            chk("halt or reboot", (i == 3) ? 16'h0003 : 16'h0002, ev);
            doReset();
        end
        give_verdict();
    end
    initial
    begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
